// ---- pkg/vrw_pkg.sv ----
// constants and types for the vendor-request register write path
package vrw_pkg;

  // setup request decode
  localparam logic [7:0]  REQ_TYPE_VENDOR_OUT = 8'h40;
  localparam logic [7:0]  REQ_REG_WRITE       = 8'h03;
  localparam logic [3:0]  CTRL_ENDPOINT       = 4'h0;

  // setup packet byte positions
  localparam logic [3:0]  SETUP_LEN           = 4'h8;
  localparam int          POS_REQ_TYPE        = 0;
  localparam int          POS_REQUEST         = 1;
  localparam int          POS_VALUE_LO        = 2;
  localparam int          POS_VALUE_HI        = 3;
  localparam int          POS_INDEX_LO        = 4;
  localparam int          POS_INDEX_HI        = 5;
  localparam int          POS_LENGTH_LO       = 6;
  localparam int          POS_LENGTH_HI       = 7;

  // output level register for pin_group_64_to_95
  localparam logic [31:0] LEVEL_REG_ADDR      = 32'hbf800928;
  localparam logic [31:0] LEVEL_REG_RESET     = 32'h00000000;
  localparam logic [16:0] WORD_BYTES          = 17'h00004;

  typedef enum logic [1:0] {
    TOK_SETUP,
    TOK_OUT,
    TOK_IN,
    TOK_OTHER
  } vrw_token_t;

  typedef enum logic [1:0] {
    HS_ACK,
    HS_NAK,
    HS_STALL,
    HS_NONE
  } vrw_handshake_t;

endpackage

// ---- tb/tb.sv ----
// self-checking bench for register writes over endpoint 0
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1;
  logic [31:0] pinDir = 32'h0, pinLevel, pinDrive, pinDriveEn;
  logic tokValid, rxValid, rxEnd, rxCrcOk, rxData1, hostAck, hsValid, zlpValid, zlpData1;
  logic [3:0] tokEndpoint;
  logic [7:0] rxByte;
  vrw_pkg::vrw_token_t tokKind;
  vrw_pkg::vrw_handshake_t hsCode;
  int n_fail = 0, n_compared = 0, cyc = 0;
  // wrong request, wrong type, wrong upper address, past the word end
  logic [63:0] badSu [4] = '{64'h0001_bf80_0928_0240, 64'h0001_bf80_0928_0341,
                             64'h0001_bf81_0928_0340, 64'h0002_bf80_092b_0340};
  always #2 sys_clk = ~sys_clk;
  vrw_host u_host (.sys_clk, .tokValid, .tokKind, .tokEndpoint, .rxValid, .rxByte, .rxEnd,
    .rxCrcOk, .rxData1, .hostAck);
  vrw_reg_write u_dut (.sys_clk, .rstn, .clkEn, .tokValid, .tokKind, .tokEndpoint, .rxValid,
    .rxByte, .rxEnd, .rxCrcOk, .rxData1, .hostAck, .pinDir, .hsValid, .hsCode, .zlpValid,
    .zlpData1, .pinLevel, .pinDrive, .pinDriveEn);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cyc == 2000) begin
    n_fail++;
    give_verdict();
  end
  task automatic wr(input logic [63:0] su, input logic [7:0] b, input logic crc,
                    input vrw_pkg::vrw_handshake_t eh, input logic [31:0] lvl);
    u_host.tok(vrw_pkg::TOK_SETUP, 4'h0);
    u_host.pkt(su, 8, 1'b1, 1'b0);
    #1;
    chk({hsValid, hsCode}, {1'b1, vrw_pkg::HS_ACK});
    @(posedge sys_clk);
    u_host.tok(vrw_pkg::TOK_OUT, 4'h0);
    u_host.pkt({56'h0, b}, 1, crc, 1'b1);
    #1;
    chk(hsValid, eh != vrw_pkg::HS_NONE);
    if (eh != vrw_pkg::HS_NONE) chk(hsCode, eh);
    chk(pinLevel, lvl);
    @(posedge sys_clk);
    if (eh == vrw_pkg::HS_NONE) return;
    u_host.tok(vrw_pkg::TOK_IN, 4'h2);
    #1;
    chk({hsValid, zlpValid}, 2'h0);
    @(posedge sys_clk);
    u_host.tok(vrw_pkg::TOK_IN, 4'h0);
    #1;
    if (eh == vrw_pkg::HS_ACK) chk({zlpValid, zlpData1}, 2'h3);
    else chk({hsValid, hsCode}, {1'b1, vrw_pkg::HS_STALL});
    @(posedge sys_clk);
    if (eh == vrw_pkg::HS_ACK) u_host.ack();
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(pinLevel | pinDrive | pinDriveEn, 32'h0);
    chk({hsValid, zlpValid, hsCode}, {2'h0, vrw_pkg::HS_NONE});
    @(posedge sys_clk);
    $display("test reset done");
    wr(64'h0001_bf80_0928_0340, 8'h80, 1'b1, vrw_pkg::HS_ACK, 32'h80);
    #1;
    chk(pinDrive, 32'h0);
    @(posedge sys_clk);
    pinDir <= 32'h80;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({pinDrive, pinDriveEn[7]}, {32'h80, 1'b1});
    @(posedge sys_clk);
    // frozen clock enable must hold the drive flops
    clkEn  <= 1'b0;
    pinDir <= 32'hff;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(pinDriveEn, 32'h80);
    @(posedge sys_clk);
    clkEn  <= 1'b1;
    pinDir <= 32'h80;
    @(posedge sys_clk);
    $display("test pin drive done");
    wr(64'h0001_bf80_092a_0340, 8'h5a, 1'b1, vrw_pkg::HS_ACK, 32'h5a0080);
    // zero length skips the data stage
    u_host.tok(vrw_pkg::TOK_SETUP, 4'h0);
    u_host.pkt(64'h0000_bf80_0928_0340, 8, 1'b1, 1'b0);
    @(posedge sys_clk);
    u_host.tok(vrw_pkg::TOK_IN, 4'h0);
    #1;
    chk({zlpValid, pinLevel}, {1'b1, 32'h5a0080});
    @(posedge sys_clk);
    u_host.ack();
    // data0 packet is acked but must not reach the register
    u_host.tok(vrw_pkg::TOK_SETUP, 4'h0);
    u_host.pkt(64'h0001_bf80_0929_0340, 8, 1'b1, 1'b0);
    @(posedge sys_clk);
    u_host.tok(vrw_pkg::TOK_OUT, 4'h0);
    u_host.pkt(64'h0000_0000_0000_0033, 1, 1'b1, 1'b0);
    #1;
    chk({hsValid, hsCode, pinLevel}, {1'b1, vrw_pkg::HS_ACK, 32'h5a0080});
    @(posedge sys_clk);
    wr(64'h0001_bf80_0928_0340, 8'h11, 1'b0, vrw_pkg::HS_NONE, 32'h5a0080);
    foreach (badSu[i]) wr(badSu[i], 8'h22, 1'b1, vrw_pkg::HS_STALL, 32'h5a0080);
    $display("test refusals done");
    rstn <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(pinLevel | pinDrive | pinDriveEn, 32'h0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(64'h0001_bf80_0928_0340, 8'h80, 1'b1, vrw_pkg::HS_ACK, 32'h80);
    #1;
    chk(pinDrive, 32'h80);
    @(posedge sys_clk);
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb

// ---- tb/vrw_host.sv ----
// host model issuing tokens and data packets
`timescale 1ns/100ps
module vrw_host (
  input  logic                sys_clk,
  output logic                tokValid = 1'b0, rxValid = 1'b0, rxEnd = 1'b0, hostAck = 1'b0,
  output logic                rxCrcOk = 1'b0, rxData1 = 1'b0,
  output vrw_pkg::vrw_token_t tokKind = vrw_pkg::TOK_OTHER,
  output logic [3:0]          tokEndpoint = 4'h0,
  output logic [7:0]          rxByte = 8'h00
);
  // callers enter at a rising edge
  task automatic tok(input vrw_pkg::vrw_token_t k, input logic [3:0] ep);
    tokValid <= 1'b1;
    tokKind <= k;
    tokEndpoint <= ep;
    @(posedge sys_clk);
    tokValid <= 1'b0;
  endtask
  task automatic pkt(input logic [63:0] d, input int n, input logic crc, input logic d1);
    for (int i = 0; i < n; i++) begin
      rxValid <= 1'b1;
      rxByte <= d[8*i+:8];
      @(posedge sys_clk);
    end
    // released line inverts so a stale byte never looks valid
    rxByte <= ~rxByte;
    rxValid <= 1'b0;
    rxEnd <= 1'b1;
    rxCrcOk <= crc;
    rxData1 <= d1;
    @(posedge sys_clk);
    rxEnd <= 1'b0;
  endtask
  task automatic ack();
    hostAck <= 1'b1;
    @(posedge sys_clk);
    hostAck <= 1'b0;
  endtask
endmodule // vrw_host

// ---- tb/vrw_reg_write_monitor.sv ----
// checker for the vendor register write path
`timescale 1ns/100ps
module vrw_chk (
  input logic                    sys_clk, rstn, clkEn, tokValid, rxEnd, rxCrcOk, rxData1,
  input vrw_pkg::vrw_token_t     tokKind,
  input logic [3:0]              tokEndpoint,
  input logic [31:0]             pinDir, pinLevel, pinDrive, pinDriveEn,
  input logic                    hsValid, zlpValid, zlpData1,
  input vrw_pkg::vrw_handshake_t hsCode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // internal reset trails rstn by two edges
  logic [1:0] upCnt_r;
  wire        upOk = upCnt_r == 2'h3;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) upCnt_r <= 2'h0;
    else if (!upOk) upCnt_r <= upCnt_r + 2'h1;
  hs_one_cycle_a: assert property (hsValid && clkEn |=> !hsValid)
    else $error("handshake too long");
  hs_cause_a: assert property (hsValid |-> $past(rxEnd) || $past(tokValid))
    else $error("handshake without cause");
  hs_code_a: assert property (hsValid |-> hsCode inside {vrw_pkg::HS_ACK, vrw_pkg::HS_STALL})
    else $error("bad handshake code");
  zlp_data1_a: assert property (zlpValid && clkEn |-> zlpData1 ##1 !zlpValid)
    else $error("status packet not one data1 pulse");
  zlp_cause_a: assert property (zlpValid |-> $past(tokValid && tokKind == vrw_pkg::TOK_IN))
    else $error("status packet without in token");
  other_ep_a: assert property (tokValid && tokEndpoint != 4'h0 |=> !hsValid && !zlpValid)
    else $error("answer on other endpoint");
  level_cause_a: assert property (upOk && $changed(pinLevel)
    |-> hsValid && $past(rxEnd && rxCrcOk && rxData1))
    else $error("level changed without clean data");
  drive_gate_a: assert property (upOk && clkEn |=> pinDriveEn == $past(pinDir)
    && pinDrive == ($past(pinLevel) & $past(pinDir)))
    else $error("pin drive not gated by direction");
  cover property (hsValid && hsCode == vrw_pkg::HS_STALL);
  cover property (zlpValid);
  cover property (upOk && $changed(pinLevel));
endmodule // vrw_chk
bind vrw_reg_write vrw_chk u_chk (.sys_clk, .rstn, .clkEn, .tokValid, .rxEnd, .rxCrcOk,
  .rxData1, .tokKind, .tokEndpoint, .pinDir, .pinLevel, .pinDrive, .pinDriveEn, .hsValid,
  .zlpValid, .zlpData1, .hsCode);

// ---- verilog/vrw_reg_write.sv ----
// control-endpoint vendor request handler writing the pin output level register
`timescale 1ns/100ps

module vrw_reg_write #(
  parameter logic [31:0] LEVEL_ADDR = vrw_pkg::LEVEL_REG_ADDR
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    clkEn,
  input  wire logic                    tokValid,
  input  wire vrw_pkg::vrw_token_t     tokKind,
  input  wire logic [3:0]              tokEndpoint,
  input  wire logic                    rxValid,
  input  wire logic [7:0]              rxByte,
  input  wire logic                    rxEnd,
  input  wire logic                    rxCrcOk,
  input  wire logic                    rxData1,
  input  wire logic                    hostAck,
  input  wire logic [31:0]             pinDir,
  output logic                         hsValid,
  output vrw_pkg::vrw_handshake_t      hsCode,
  output logic                         zlpValid,
  output logic                         zlpData1,
  output logic [31:0]                  pinLevel,
  output logic [31:0]                  pinDrive,
  output logic [31:0]                  pinDriveEn
);

  // lane steering assumes the register starts on a word boundary
  if (LEVEL_ADDR[1:0] != 2'b00) begin : g_addr_check
    $error("LEVEL_ADDR must be word aligned");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP_RX,
    ST_DATA_WAIT,
    ST_DATA_RX,
    ST_STATUS_WAIT,
    ST_STATUS_ACK
  } vrw_state_t;

  // reset release through two flops
  logic [1:0]           rstSync_r;
  logic                 rstnInt;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_r[1];

  vrw_state_t           state_r,    state_nxt;
  logic [7:0]           setupBuf_r [8];
  logic [3:0]           rxCnt_r,    rxCnt_nxt;
  logic                 stall_r,    stall_nxt;
  logic [31:0]          pendData_r, pendData_nxt;
  logic [3:0]           pendMask_r, pendMask_nxt;
  logic [31:0]          level_r,    level_nxt;
  logic                 hsValid_r,  hsValid_nxt;
  vrw_pkg::vrw_handshake_t hsCode_r, hsCode_nxt;
  logic                 zlp_r,      zlp_nxt;
  logic                 zlpD1_r,    zlpD1_nxt;
  logic [31:0]          drive_r;
  logic [31:0]          driveEn_r;

  // setup field decode
  wire  logic [31:0]    reqAddr;
  wire  logic [15:0]    reqLen;
  wire  logic           reqIsWrite;
  wire  logic           addrHit;
  wire  logic           lenFits;
  wire  logic           onCtrlEp;
  wire  logic           setupTok;
  wire  logic [1:0]     rxLane;
  wire  logic           dataCountOk;

  assign reqAddr    = {setupBuf_r[vrw_pkg::POS_INDEX_HI], setupBuf_r[vrw_pkg::POS_INDEX_LO],
                       setupBuf_r[vrw_pkg::POS_VALUE_HI], setupBuf_r[vrw_pkg::POS_VALUE_LO]};
  assign reqLen     = {setupBuf_r[vrw_pkg::POS_LENGTH_HI], setupBuf_r[vrw_pkg::POS_LENGTH_LO]};
  assign reqIsWrite = setupBuf_r[vrw_pkg::POS_REQ_TYPE] == vrw_pkg::REQ_TYPE_VENDOR_OUT &&
                      setupBuf_r[vrw_pkg::POS_REQUEST] == vrw_pkg::REQ_REG_WRITE;
  assign addrHit    = reqAddr[31:2] == LEVEL_ADDR[31:2];
  // bytes must stay inside the one word; longer writes are refused, not wrapped
  assign lenFits    = ({15'h0000, reqAddr[1:0]} + {1'b0, reqLen}) <= vrw_pkg::WORD_BYTES;
  assign onCtrlEp   = tokValid && tokEndpoint == vrw_pkg::CTRL_ENDPOINT;
  assign setupTok   = onCtrlEp && tokKind == vrw_pkg::TOK_SETUP;
  assign rxLane     = reqAddr[1:0] + rxCnt_r[1:0];
  assign dataCountOk = {12'h000, rxCnt_r} == reqLen;

  always_comb begin
    state_nxt    = state_r;
    rxCnt_nxt    = rxCnt_r;
    stall_nxt    = stall_r;
    pendData_nxt = pendData_r;
    pendMask_nxt = pendMask_r;
    level_nxt    = level_r;
    hsValid_nxt  = 1'b0;
    hsCode_nxt   = hsCode_r;
    zlp_nxt      = 1'b0;
    zlpD1_nxt    = zlpD1_r;
    if (setupTok) begin
      // a setup always aborts whatever transfer was in flight
      state_nxt = ST_SETUP_RX;
      rxCnt_nxt = 4'h0;
    end else begin
      case (state_r)
        ST_SETUP_RX: begin
          // count one past eight so an overlong setup is refused
          if (rxValid && rxCnt_r <= vrw_pkg::SETUP_LEN) begin
            rxCnt_nxt = rxCnt_r + 4'h1;
          end
          if (rxEnd) begin
            if (rxCrcOk && rxCnt_r == vrw_pkg::SETUP_LEN) begin
              hsValid_nxt = 1'b1;
              hsCode_nxt  = vrw_pkg::HS_ACK;
              stall_nxt   = !(reqIsWrite && addrHit && lenFits);
              state_nxt   = (reqLen == 16'h0000) ? ST_STATUS_WAIT : ST_DATA_WAIT;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_DATA_WAIT: begin
          if (onCtrlEp && tokKind == vrw_pkg::TOK_OUT) begin
            rxCnt_nxt    = 4'h0;
            pendMask_nxt = 4'h0;
            state_nxt    = ST_DATA_RX;
          end
        end
        ST_DATA_RX: begin
          if (rxValid && rxCnt_r < vrw_pkg::SETUP_LEN) begin
            rxCnt_nxt = rxCnt_r + 4'h1;
            if ({12'h000, rxCnt_r} < reqLen) begin
              pendData_nxt[rxLane*8 +: 8] = rxByte;
              pendMask_nxt[rxLane]        = 1'b1;
            end
          end
          if (rxEnd) begin
            state_nxt = ST_DATA_WAIT;
            if (!rxCrcOk) begin
              // corrupt packet: stay silent so the host retries
              state_nxt = ST_DATA_WAIT;
            end else if (stall_r || !dataCountOk) begin
              // refused data stalls the status stage as well
              hsValid_nxt = 1'b1;
              hsCode_nxt  = vrw_pkg::HS_STALL;
              stall_nxt   = 1'b1;
              state_nxt   = ST_STATUS_WAIT;
            end else if (!rxData1) begin
              // repeat of a packet already taken: ack it, keep the register
              hsValid_nxt = 1'b1;
              hsCode_nxt  = vrw_pkg::HS_ACK;
            end else begin
              hsValid_nxt = 1'b1;
              hsCode_nxt  = vrw_pkg::HS_ACK;
              for (int b = 0; b < 4; b++) begin
                if (pendMask_r[b]) begin
                  level_nxt[b*8 +: 8] = pendData_r[b*8 +: 8];
                end
              end
              state_nxt = ST_STATUS_WAIT;
            end
          end
        end
        ST_STATUS_WAIT, ST_STATUS_ACK: begin
          if (onCtrlEp && tokKind == vrw_pkg::TOK_IN) begin
            if (stall_r) begin
              hsValid_nxt = 1'b1;
              hsCode_nxt  = vrw_pkg::HS_STALL;
            end else begin
              zlp_nxt   = 1'b1;
              zlpD1_nxt = 1'b1;
              state_nxt = ST_STATUS_ACK;
            end
          end else if (state_r == ST_STATUS_ACK && hostAck) begin
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      state_r    <= ST_IDLE;
      rxCnt_r    <= 4'h0;
      stall_r    <= 1'b0;
      pendData_r <= 32'h00000000;
      pendMask_r <= 4'h0;
      level_r    <= vrw_pkg::LEVEL_REG_RESET;
      hsValid_r  <= 1'b0;
      hsCode_r   <= vrw_pkg::HS_NONE;
      zlp_r      <= 1'b0;
      zlpD1_r    <= 1'b0;
    end else if (clkEn) begin
      state_r    <= state_nxt;
      rxCnt_r    <= rxCnt_nxt;
      stall_r    <= stall_nxt;
      pendData_r <= pendData_nxt;
      pendMask_r <= pendMask_nxt;
      level_r    <= level_nxt;
      hsValid_r  <= hsValid_nxt;
      hsCode_r   <= hsCode_nxt;
      zlp_r      <= zlp_nxt;
      zlpD1_r    <= zlpD1_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      for (int i = 0; i < 8; i++) begin
        setupBuf_r[i] <= 8'h00;
      end
    end else if (clkEn && state_r == ST_SETUP_RX && rxValid && rxCnt_r < vrw_pkg::SETUP_LEN) begin
      setupBuf_r[rxCnt_r[2:0]] <= rxByte;
    end
  end

  // level only reaches a pin whose direction bit already says output
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      drive_r   <= 32'h00000000;
      driveEn_r <= 32'h00000000;
    end else if (clkEn) begin
      drive_r   <= level_r & pinDir;
      driveEn_r <= pinDir;
    end
  end

  assign hsValid    = hsValid_r;
  assign hsCode     = hsCode_r;
  assign zlpValid   = zlp_r;
  assign zlpData1   = zlpD1_r;
  assign pinLevel   = level_r;
  assign pinDrive   = drive_r;
  assign pinDriveEn = driveEn_r;

endmodule // vrw_reg_write
